//--- design/rpc_pkg.sv
// Summary of operation
// - Fault-code processing enable makes the receiver act on local fault codes; default off.
// - With processing enabled, no packets are delivered while the fault persists.
// - A packet in flight at fault onset ends early with error flagged.
// - After the fault clears, delivery waits for a received start block.
// - Configurable 48-bit unicast pause destination address, reset to zero.
// - Configurable 48-bit multicast pause destination address, reset to control multicast.
// - Configurable 48-bit pause source address, reset to zero.
// - Global control class: ethertype 8808 default, opcode low and high bounds.
// - Priority control class: own ethertype and opcode low and high bounds.
// - Global pause: ethertype 8808 and opcode 0001 by default.
// - Priority pause: ethertype 8808 and opcode 0101 by default.
package rpc_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h00C;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h010;
  localparam logic [11:0] OFS_UCAST_LO  = 12'h020;
  localparam logic [11:0] OFS_UCAST_HI  = 12'h024;
  localparam logic [11:0] OFS_MCAST_LO  = 12'h028;
  localparam logic [11:0] OFS_MCAST_HI  = 12'h02C;
  localparam logic [11:0] OFS_SRC_LO    = 12'h030;
  localparam logic [11:0] OFS_SRC_HI    = 12'h034;
  localparam logic [11:0] OFS_GCP_ETYPE = 12'h040;
  localparam logic [11:0] OFS_GCP_OPS   = 12'h044;
  localparam logic [11:0] OFS_PCP_ETYPE = 12'h048;
  localparam logic [11:0] OFS_PCP_OPS   = 12'h04C;
  localparam logic [11:0] OFS_GPP       = 12'h050;
  localparam logic [11:0] OFS_PPP       = 12'h054;

  // Reset values
  localparam logic [47:0] RST_UCAST   = 48'h000000000000;
  localparam logic [47:0] RST_MCAST   = 48'h0180C2000001;
  localparam logic [47:0] RST_SRC     = 48'h000000000000;
  localparam logic [15:0] RST_ETYPE   = 16'h8808;
  localparam logic [15:0] RST_OP_LOW  = 16'h0000;
  localparam logic [15:0] RST_OP_HIGH = 16'h0FFF;
  localparam logic [15:0] RST_GPP_OP  = 16'h0001;
  localparam logic [15:0] RST_PPP_OP  = 16'h0101;

  // Event and status bit positions
  localparam int EV_FAULT_SET = 0;
  localparam int EV_FAULT_CLR = 1;
  localparam int EV_TRUNC     = 2;
  localparam int EV_GPP       = 3;
  localparam int EV_PPP       = 4;
  localparam int EV_GCP       = 5;
  localparam int EV_PCP       = 6;
  localparam int EV_W         = 7;

  typedef enum logic [1:0] {
    GS_RUN   = 2'b00,
    GS_FAULT = 2'b01,
    GS_WAIT  = 2'b11
  } rpc_gate_t;

  typedef struct packed {
    logic [47:0] ucast;
    logic [47:0] mcast;
    logic [47:0] src;
    logic [15:0] gcp_etype;
    logic [15:0] gcp_low;
    logic [15:0] gcp_high;
    logic [15:0] pcp_etype;
    logic [15:0] pcp_low;
    logic [15:0] pcp_high;
    logic [15:0] gpp_etype;
    logic [15:0] gpp_op;
    logic [15:0] ppp_etype;
    logic [15:0] ppp_op;
  } rpc_match_cfg_t;

  // One segment of the user packet bus
  typedef struct packed {
    logic [127:0] data;
    logic         ena;
    logic         sop;
    logic         eop;
    logic         err;
    logic [3:0]   mty;
  } rpc_seg_t;

  // Header fields of a received frame, valid while the valid field is set
  typedef struct packed {
    logic        valid;
    logic [47:0] dest;
    logic [47:0] src;
    logic [15:0] etype;
    logic [15:0] opcode;
  } rpc_hdr_t;

  typedef struct packed {
    logic gpp;
    logic ppp;
    logic gcp;
    logic pcp;
  } rpc_class_t;

endpackage : rpc_pkg

//--- design/rpc_top.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module rpc_top (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  // Line side, from the PCS lane decoder
  input  wire logic               line_fault_code,
  input  wire logic               line_start_block,
  input  wire rpc_pkg::rpc_seg_t  line_seg,
  input  wire rpc_pkg::rpc_hdr_t  line_hdr,
  // User segment bus
  output rpc_pkg::rpc_seg_t       user_segment_bus,
  // Classification result, one-cycle pulses
  output rpc_pkg::rpc_class_t     rx_class,
  // Interrupt
  output logic                    irq
);

  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    rd_miss;
    logic                    fault_en;
    rpc_pkg::rpc_match_cfg_t cfg;
    rpc_pkg::rpc_gate_t      gate;
    logic                    in_pkt;
    logic                    fault_s1;
    logic                    fault_s2;
    rpc_pkg::rpc_seg_t       seg;
    rpc_pkg::rpc_class_t     cls;
    logic [rpc_pkg::EV_W-1:0] ev_stat;
    logic [rpc_pkg::EV_W-1:0] ev_en;
    logic                    irq;
  } rpc_state_t;

  rpc_state_t s_q;
  rpc_state_t s_d;

  logic       wr_acc;
  logic       rd_acc;
  logic       fault_act;
  logic       pass;
  logic       hit;
  logic [rpc_pkg::EV_W-1:0] ev;
  rpc_pkg::rpc_class_t cls_n;
  logic       dest_ok;

  assign wr_acc = psel & penable & pwrite & ~s_q.pready;
  assign rd_acc = psel & ~penable & ~pwrite;

  always_comb begin
    s_d     = s_q;
    hit     = 1'b1;
    ev      = '0;
    cls_n   = '0;
    dest_ok = 1'b0;
    pass    = 1'b0;

    // Fault input from another domain, two stages
    s_d.fault_s1 = line_fault_code;
    s_d.fault_s2 = s_q.fault_s1;
    fault_act = s_q.fault_en & s_q.fault_s2;

    // Gate state machine
    s_d.seg = '0;
    case (s_q.gate)
      rpc_pkg::GS_RUN: begin
        if (fault_act) begin
          s_d.gate = rpc_pkg::GS_FAULT;
          ev[rpc_pkg::EV_FAULT_SET] = 1'b1;
          if (s_q.in_pkt) begin
            s_d.seg.ena = 1'b1;
            s_d.seg.eop = 1'b1;
            s_d.seg.err = 1'b1;
            s_d.in_pkt  = 1'b0;
            ev[rpc_pkg::EV_TRUNC] = 1'b1;
          end
        end else begin
          pass = 1'b1;
        end
      end
      rpc_pkg::GS_FAULT: begin
        if (!fault_act) begin
          s_d.gate = rpc_pkg::GS_WAIT;
          ev[rpc_pkg::EV_FAULT_CLR] = 1'b1;
        end
      end
      rpc_pkg::GS_WAIT: begin
        if (fault_act) begin
          s_d.gate = rpc_pkg::GS_FAULT;
        end else if (line_start_block) begin
          s_d.gate = rpc_pkg::GS_RUN;
          pass     = 1'b1;
        end
      end
      default: s_d.gate = rpc_pkg::GS_WAIT;
    endcase

    // Forward segments; a packet must begin with sop after a fault
    if (pass && line_seg.ena && (s_q.in_pkt || line_seg.sop)) begin
      s_d.seg = line_seg;
      if (line_seg.eop) begin
        s_d.in_pkt = 1'b0;
      end else begin
        s_d.in_pkt = 1'b1;
      end
    end

    dest_ok = (line_hdr.dest == s_q.cfg.ucast) ||
              (line_hdr.dest == s_q.cfg.mcast);
    if (line_hdr.valid && pass) begin
      cls_n.gpp = dest_ok && line_hdr.etype == s_q.cfg.gpp_etype &&
                  line_hdr.opcode == s_q.cfg.gpp_op;
      cls_n.ppp = dest_ok && line_hdr.etype == s_q.cfg.ppp_etype &&
                  line_hdr.opcode == s_q.cfg.ppp_op;
      cls_n.gcp = line_hdr.etype == s_q.cfg.gcp_etype &&
                  line_hdr.opcode >= s_q.cfg.gcp_low &&
                  line_hdr.opcode <= s_q.cfg.gcp_high;
      cls_n.pcp = line_hdr.etype == s_q.cfg.pcp_etype &&
                  line_hdr.opcode >= s_q.cfg.pcp_low &&
                  line_hdr.opcode <= s_q.cfg.pcp_high;
    end
    s_d.cls = cls_n;
    ev[rpc_pkg::EV_GPP] = cls_n.gpp;
    ev[rpc_pkg::EV_PPP] = cls_n.ppp;
    ev[rpc_pkg::EV_GCP] = cls_n.gcp;
    ev[rpc_pkg::EV_PCP] = cls_n.pcp;

    // APB: one wait state, answer in second access cycle
    s_d.pready  = psel & penable & ~s_q.pready;
    s_d.pslverr = 1'b0;
    if (rd_acc) begin
      s_d.prdata = '0;
      case (paddr)
        rpc_pkg::OFS_CTRL:      s_d.prdata[0] = s_q.fault_en;
        rpc_pkg::OFS_STATUS:    s_d.prdata[1:0] = s_q.gate;
        rpc_pkg::OFS_IRQ_STAT:  s_d.prdata[rpc_pkg::EV_W-1:0] = s_q.ev_stat;
        rpc_pkg::OFS_IRQ_EN:    s_d.prdata[rpc_pkg::EV_W-1:0] = s_q.ev_en;
        rpc_pkg::OFS_IRQ_CLR:   s_d.prdata = '0;
        rpc_pkg::OFS_UCAST_LO:  s_d.prdata = s_q.cfg.ucast[31:0];
        rpc_pkg::OFS_UCAST_HI:  s_d.prdata[15:0] = s_q.cfg.ucast[47:32];
        rpc_pkg::OFS_MCAST_LO:  s_d.prdata = s_q.cfg.mcast[31:0];
        rpc_pkg::OFS_MCAST_HI:  s_d.prdata[15:0] = s_q.cfg.mcast[47:32];
        rpc_pkg::OFS_SRC_LO:    s_d.prdata = s_q.cfg.src[31:0];
        rpc_pkg::OFS_SRC_HI:    s_d.prdata[15:0] = s_q.cfg.src[47:32];
        rpc_pkg::OFS_GCP_ETYPE: s_d.prdata[15:0] = s_q.cfg.gcp_etype;
        rpc_pkg::OFS_GCP_OPS:
          s_d.prdata = {s_q.cfg.gcp_high, s_q.cfg.gcp_low};
        rpc_pkg::OFS_PCP_ETYPE: s_d.prdata[15:0] = s_q.cfg.pcp_etype;
        rpc_pkg::OFS_PCP_OPS:
          s_d.prdata = {s_q.cfg.pcp_high, s_q.cfg.pcp_low};
        rpc_pkg::OFS_GPP:
          s_d.prdata = {s_q.cfg.gpp_op, s_q.cfg.gpp_etype};
        rpc_pkg::OFS_PPP:
          s_d.prdata = {s_q.cfg.ppp_op, s_q.cfg.ppp_etype};
        default: hit = 1'b0;
      endcase
      s_d.pslverr = 1'b0;
    end

    // Status clear first so a same-cycle event wins
    if (wr_acc) begin
      case (paddr)
        rpc_pkg::OFS_CTRL:      s_d.fault_en = pwdata[0];
        rpc_pkg::OFS_STATUS:    hit = 1'b1;
        rpc_pkg::OFS_IRQ_STAT:  hit = 1'b1;
        rpc_pkg::OFS_IRQ_EN:
          s_d.ev_en = pwdata[rpc_pkg::EV_W-1:0];
        rpc_pkg::OFS_IRQ_CLR:
          s_d.ev_stat = s_q.ev_stat & ~pwdata[rpc_pkg::EV_W-1:0];
        rpc_pkg::OFS_UCAST_LO:  s_d.cfg.ucast[31:0] = pwdata;
        rpc_pkg::OFS_UCAST_HI:  s_d.cfg.ucast[47:32] = pwdata[15:0];
        rpc_pkg::OFS_MCAST_LO:  s_d.cfg.mcast[31:0] = pwdata;
        rpc_pkg::OFS_MCAST_HI:  s_d.cfg.mcast[47:32] = pwdata[15:0];
        rpc_pkg::OFS_SRC_LO:    s_d.cfg.src[31:0] = pwdata;
        rpc_pkg::OFS_SRC_HI:    s_d.cfg.src[47:32] = pwdata[15:0];
        rpc_pkg::OFS_GCP_ETYPE: s_d.cfg.gcp_etype = pwdata[15:0];
        rpc_pkg::OFS_GCP_OPS: begin
          s_d.cfg.gcp_low  = pwdata[15:0];
          s_d.cfg.gcp_high = pwdata[31:16];
        end
        rpc_pkg::OFS_PCP_ETYPE: s_d.cfg.pcp_etype = pwdata[15:0];
        rpc_pkg::OFS_PCP_OPS: begin
          s_d.cfg.pcp_low  = pwdata[15:0];
          s_d.cfg.pcp_high = pwdata[31:16];
        end
        rpc_pkg::OFS_GPP: begin
          s_d.cfg.gpp_etype = pwdata[15:0];
          s_d.cfg.gpp_op    = pwdata[31:16];
        end
        rpc_pkg::OFS_PPP: begin
          s_d.cfg.ppp_etype = pwdata[15:0];
          s_d.cfg.ppp_op    = pwdata[31:16];
        end
        default: hit = 1'b0;
      endcase
    end
    // Read miss decoded in setup, answered later with pready
    if (rd_acc) begin
      s_d.rd_miss = ~hit;
    end
    if (wr_acc) begin
      s_d.pslverr = ~hit;
    end else if (s_d.pready) begin
      s_d.pslverr = s_q.rd_miss;
    end

    s_d.ev_stat = s_d.ev_stat | ev;
    s_d.irq     = |(s_d.ev_stat & s_d.ev_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                 <= '0;
      s_q.gate            <= rpc_pkg::GS_RUN;
      s_q.cfg.ucast       <= rpc_pkg::RST_UCAST;
      s_q.cfg.mcast       <= rpc_pkg::RST_MCAST;
      s_q.cfg.src         <= rpc_pkg::RST_SRC;
      s_q.cfg.gcp_etype   <= rpc_pkg::RST_ETYPE;
      s_q.cfg.gcp_low     <= rpc_pkg::RST_OP_LOW;
      s_q.cfg.gcp_high    <= rpc_pkg::RST_OP_HIGH;
      s_q.cfg.pcp_etype   <= rpc_pkg::RST_ETYPE;
      s_q.cfg.pcp_low     <= rpc_pkg::RST_OP_LOW;
      s_q.cfg.pcp_high    <= rpc_pkg::RST_OP_HIGH;
      s_q.cfg.gpp_etype   <= rpc_pkg::RST_ETYPE;
      s_q.cfg.gpp_op      <= rpc_pkg::RST_GPP_OP;
      s_q.cfg.ppp_etype   <= rpc_pkg::RST_ETYPE;
      s_q.cfg.ppp_op      <= rpc_pkg::RST_PPP_OP;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign prdata           = s_q.prdata;
  assign user_segment_bus = s_q.seg;
  assign rx_class         = s_q.cls;
  assign irq              = s_q.irq;

endmodule // rpc_top

//--- test/rpc_top_sva.sv
`timescale 1ns/1ps
module rpc_top_sva (
  // Clock, reset and APB
  input logic                pclk,
  input logic                presetn,
  input logic                psel,
  input logic                penable,
  input logic                pready,
  input logic                pslverr,
  input logic [31:0]         prdata,
  // Stream and classification
  input rpc_pkg::rpc_seg_t   line_seg,
  input rpc_pkg::rpc_hdr_t   line_hdr,
  input rpc_pkg::rpc_seg_t   user_segment_bus,
  input rpc_pkg::rpc_class_t rx_class
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pready_one_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  pready_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  pready_idle_a: assert property (!psel |=> !pready)
    else $error("pready without select");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  prdata_hold_a: assert property (psel && penable && !pready |=> $stable(prdata))
    else $error("read data moved in access");
  seg_pass_a: assert property (
    user_segment_bus.ena && !user_segment_bus.err |-> $past(line_seg.ena)
    && user_segment_bus.data == $past(line_seg.data))
    else $error("segment not from line");
  sop_pass_a: assert property (
    user_segment_bus.sop |-> $past(line_seg.sop) && $past(line_seg.ena))
    else $error("start of packet not from line");
  trunc_mark_a: assert property (
    user_segment_bus.err && !$past(line_seg.err) |->
    user_segment_bus.eop && user_segment_bus.ena)
    else $error("forced error without end");
  class_cause_a: assert property (rx_class != '0 |-> $past(line_hdr.valid))
    else $error("class pulse without header");
  cover property (pslverr);
  cover property (user_segment_bus.err && user_segment_bus.eop);
  cover property (rx_class.gpp);
endmodule // rpc_top_sva

bind rpc_top rpc_top_sva i_rpc_top_sva (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .prdata, .line_seg, .line_hdr, .user_segment_bus,
  .rx_class);

//--- test/rpc_line_model.sv
`timescale 1ns/1ps
module rpc_line_model (
  // Clock
  input  logic              pclk,
  // Line side toward the receiver
  output rpc_pkg::rpc_seg_t line_seg,
  output rpc_pkg::rpc_hdr_t line_hdr,
  output logic              line_fault_code,
  output logic              line_start_block
);
  initial begin
    line_seg = '0;
    line_hdr = '0;
    line_fault_code = 1'h0;
    line_start_block = 1'h0;
  end
  // Idle lines show the inverse, so stale data cannot pass for fresh
  task automatic seg(input logic s, e, st, output logic [127:0] d);
    d = {$urandom, $urandom, $urandom, $urandom};
    @(posedge pclk);
    line_seg <= '{d, 1'h1, s, e, 1'h0, 4'h0};
    line_start_block <= st;
    @(posedge pclk);
    line_seg <= '{~d, 1'h0, ~s, ~e, 1'h0, 4'hF};
    line_start_block <= 1'h0;
  endtask
  task automatic hdr(input logic [47:0] da, input logic [15:0] et, op);
    @(posedge pclk);
    line_hdr <= '{1'h1, da, 48'h0, et, op};
    @(posedge pclk);
    line_hdr <= '{1'h0, ~da, 48'hFFFFFFFFFFFF, ~et, ~op};
  endtask
  task automatic flt(input logic v);
    @(posedge pclk);
    line_fault_code <= v;
  endtask
endmodule // rpc_line_model

//--- test/rpc_top_tb.sv
`timescale 1ns/1ps
module rpc_top_tb;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                irq, line_fault_code, line_start_block;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, r;
  rpc_pkg::rpc_seg_t   line_seg, user_segment_bus, es, q_seg[$];
  rpc_pkg::rpc_hdr_t   line_hdr;
  rpc_pkg::rpc_class_t rx_class, q_cls[$];
  logic [32:0]         ea, q_apb[$];
  logic [127:0]        d;
  int                  num_errors, checks, cyc, tn;
  logic [43:0] rv [13] = '{44'h000_00000000, 44'h020_00000000,
    44'h024_00000000, 44'h028_C2000001, 44'h02C_00000180, 44'h030_00000000,
    44'h034_00000000, 44'h040_00008808, 44'h044_0FFF0000, 44'h048_00008808,
    44'h04C_0FFF0000, 44'h050_00018808, 44'h054_01018808};
  logic [83:0] ct [10] = '{84'h0180C2000001_8808_0001_9,
    84'h020000000003_8808_0101_5, 84'h0A0000000001_8808_0001_1,
    84'h0180C2000001_8808_0005_3, 84'h0180C2000001_8808_0010_3,
    84'h0180C2000001_8808_0004_1, 84'h0180C2000001_8808_0011_1,
    84'h0180C2000001_8808_0FFF_1, 84'h0180C2000001_8808_1000_0,
    84'h0180C2000001_8809_0001_0};

  rpc_top i_rpc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .line_fault_code, .line_start_block,
    .line_seg, .line_hdr, .user_segment_bus, .rx_class, .irq);
  rpc_line_model i_line (.pclk, .line_seg, .line_hdr, .line_fault_code,
    .line_start_block);

  always #5 pclk = ~pclk;

  task automatic chk(input logic [135:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tdone();
    tn++;
    $display("test %0d done", tn);
  endtask
  // Each access notes its expectation; bit 32 means an error answer
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    q_apb.push_back(e);
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic send(input logic s, e, st);
    i_line.seg(s, e, st, d);
    q_seg.push_back('{d, 1'h1, s, e, 1'h0, 4'h0});
  endtask
  task automatic irqc(input logic e);
    repeat (2) @(posedge pclk);
    #1 chk(irq, e);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (pready === 1'h1) begin
      ea = q_apb.size() ? q_apb.pop_front() : '1;
      if (ea[32] || pwrite) chk(pslverr, ea[32]);
      else chk({pslverr, prdata}, ea);
    end
    if (user_segment_bus.ena === 1'h1) begin
      es = q_seg.size() ? q_seg.pop_front() : '1;
      if (es.err) chk({user_segment_bus.eop, user_segment_bus.err}, 2'h3);
      else chk(user_segment_bus, es);
    end
    if (rx_class !== 4'h0) chk(rx_class, q_cls.size() ? q_cls.pop_front() : 4'h0);
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    r = $urandom(54);
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rv[i]) apb(1'h0, rv[i][43:32], 32'h0, {1'h0, rv[i][31:0]});
    apb(1'h0, 12'h0FC, 32'h0, 33'h100000000);
    apb(1'h1, 12'h0F8, 32'h0, 33'h100000000);
    tdone();
    r = $urandom;
    apb(1'h1, 12'h030, r, 33'h0);
    apb(1'h0, 12'h030, 32'h0, {1'h0, r});
    apb(1'h1, 12'h020, 32'h00000003, 33'h0);
    apb(1'h1, 12'h024, 32'h00000200, 33'h0);
    apb(1'h1, 12'h044, 32'h00100005, 33'h0);
    tdone();
    foreach (ct[i]) begin
      if (ct[i][3:0] != 4'h0) q_cls.push_back(ct[i][3:0]);
      i_line.hdr(ct[i][83:36], ct[i][35:20], ct[i][19:4]);
    end
    tdone();
    i_line.flt(1'h1);
    repeat (4) @(posedge pclk);
    send(1'h1, 1'h0, 1'h0);
    send(1'h0, 1'h1, 1'h0);
    i_line.flt(1'h0);
    tdone();
    apb(1'h1, 12'h000, 32'h1, 33'h0);
    apb(1'h1, 12'h010, 32'h7F, 33'h0);
    apb(1'h1, 12'h00C, 32'h0, 33'h0);
    send(1'h1, 1'h0, 1'h0);
    q_seg.push_back('{err: 1'h1, ena: 1'h1, eop: 1'h1, default: '0});
    i_line.flt(1'h1);
    repeat (6) @(posedge pclk);
    i_line.seg(1'h1, 1'h1, 1'h0, d);
    apb(1'h0, 12'h004, 32'h0, 33'h1);
    i_line.flt(1'h0);
    repeat (6) @(posedge pclk);
    i_line.seg(1'h1, 1'h1, 1'h0, d);
    apb(1'h0, 12'h004, 32'h0, 33'h3);
    send(1'h1, 1'h0, 1'h1);
    send(1'h0, 1'h1, 1'h0);
    tdone();
    apb(1'h0, 12'h008, 32'h0, 33'h7);
    irqc(1'h0);
    apb(1'h1, 12'h00C, 32'h4, 33'h0);
    irqc(1'h1);
    apb(1'h1, 12'h010, 32'h4, 33'h0);
    irqc(1'h0);
    apb(1'h0, 12'h010, 32'h0, 33'h0);
    apb(1'h0, 12'h008, 32'h0, 33'h3);
    tdone();
    // Let the monitor take the last answer first
    repeat (2) @(posedge pclk);
    chk(q_apb.size() + q_seg.size() + q_cls.size(), 0);
    print_verdict();
  end
endmodule // rpc_top_tb
